// *** stcs_host_model.sv ***
/* Host controller model: drives the torque source selects, the mode switch
   and the analog reference. Assumes the bench calls its task. */
`timescale 1ns/1ps
`default_nettype none
module stcs_host_model
(
    input  wire logic              aclk,
    output var logic               torque_source_select0,
    output var logic               torque_source_select1,
    output var logic               dual_mode_switch,
    output var logic signed [15:0] analog_torque_mv
);
    // The pins are always driven, so the synchroniser never sees a float.
    initial
    begin
        torque_source_select0 = 1'h0;
        torque_source_select1 = 1'h0;
        dual_mode_switch = 1'h0;
        analog_torque_mv = 16'h0000;
    end
    // Pins change just after an edge and then hold, like a real controller.
    task automatic drive(input logic [1:0] src, input logic sw, input logic signed [15:0] mv);
        @(posedge aclk);
        torque_source_select1 <= src[1];
        torque_source_select0 <= src[0];
        dual_mode_switch <= sw;
        analog_torque_mv <= mv;
    endtask
endmodule
`default_nettype wire

// *** stcs_lpf.sv ***
/*
 * First-order low-pass filter for the analog torque input, stepped once per
 * millisecond. Assumes a sample on the same clock; a time of zero bypasses.
 */
`timescale 1ns/1ps
`default_nettype none
module stcs_lpf
    import stcs_pkg::*;
#(
    parameter int TICK_CYCLES = STCS_TICK_CYCLES
)
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic signed [15:0] x_in,
    input  wire logic        [15:0] time_ms,
    output logic signed      [15:0] y_out
);
    logic        [31:0] tick_q;
    logic        [31:0] tick_d;
    logic signed [31:0] acc_q;
    logic signed [31:0] acc_d;
    logic signed [31:0] err;
    logic        [3:0]  shift;

    // Gain is rounded to a power of two: cheap, at the cost of a time
    // constant that is exact only for powers of two.
    always_comb
    begin
        shift = 4'h0;
        for (int k = 1; k < 11; k++)
        begin
            if (time_ms > (16'h0001 << (k - 1)))
            begin
                shift = 4'(k);
            end
        end
        err    = (32'(x_in) <<< STCS_FRAC_BITS) - acc_q;
        tick_d = (tick_q >= 32'(TICK_CYCLES - 1)) ? 32'h00000000 : tick_q + 32'h00000001;
        acc_d  = acc_q;
        if (time_ms == 16'h0000)
        begin
            acc_d = 32'(x_in) <<< STCS_FRAC_BITS;
        end
        else if (tick_q == 32'h00000000)
        begin
            acc_d = acc_q + (err >>> shift);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            tick_q <= 32'h00000000;
            acc_q  <= 32'sh00000000;
        end
        else
        begin
            tick_q <= tick_d;
            acc_q  <= acc_d;
        end
    end

    assign y_out = acc_q[31:16];
endmodule
`default_nettype wire

// *** stcs_pkg.sv ***
/*
 * Shared constants of the torque command unit: register indexes, reset values,
 * control mode codes, source select codes, limits and timing figures.
 * Assumes an AXI4-Lite master with 32-bit data; byte address = 4 x index.
 */
`default_nettype none
package stcs_pkg;
    // Register indexes; the byte address on the bus is four times the index.
    localparam logic [9:0]  STCS_IDX_MODE        = 10'h102;
    localparam logic [9:0]  STCS_IDX_FILTER_TIME = 10'h10E;
    localparam logic [9:0]  STCS_IDX_PARAM_A     = 10'h118;
    localparam logic [9:0]  STCS_IDX_PARAM_B     = 10'h11A;
    localparam logic [9:0]  STCS_IDX_PARAM_C     = 10'h11C;
    localparam logic [9:0]  STCS_IDX_FULL_SCALE  = 10'h152;
    localparam logic [9:0]  STCS_IDX_STATUS      = 10'h180;
    // Values after reset.
    localparam logic [15:0] STCS_RST_FILTER_TIME = 16'h0000;
    localparam logic [15:0] STCS_RST_FULL_SCALE  = 16'h0064;
    localparam logic [15:0] STCS_RST_PARAM       = 16'h0000;
    localparam logic [7:0]  STCS_RST_MODE        = 8'h03;
    // Control mode codes.
    localparam logic [7:0]  STCS_MODE_PT   = 8'h00;
    localparam logic [7:0]  STCS_MODE_PR   = 8'h01;
    localparam logic [7:0]  STCS_MODE_S    = 8'h02;
    localparam logic [7:0]  STCS_MODE_T    = 8'h03;
    localparam logic [7:0]  STCS_MODE_SZ   = 8'h04;
    localparam logic [7:0]  STCS_MODE_TZ   = 8'h05;
    localparam logic [7:0]  STCS_MODE_PT_S = 8'h06;
    localparam logic [7:0]  STCS_MODE_PT_T = 8'h07;
    localparam logic [7:0]  STCS_MODE_S_T  = 8'h0A;
    // Torque source select patterns {select1, select0}.
    typedef enum logic [1:0]
    {
        STCS_SRC_ANALOG  = 2'b00,
        STCS_SRC_PARAM_A = 2'b01,
        STCS_SRC_PARAM_B = 2'b10,
        STCS_SRC_PARAM_C = 2'b11
    } stcs_src_t;
    // Limits: internal parameters in percent, scaling and filter settings.
    localparam logic signed [15:0] STCS_PARAM_MAX  = 16'sh01D6;
    localparam logic signed [15:0] STCS_PARAM_MIN  = -16'sh01D6;
    localparam logic [15:0]        STCS_SETTING_MAX = 16'h03E8;
    // Millivolts per volt times the divisor 10 of the scaling formula.
    localparam int                 STCS_MV_DIVISOR = 10000;
    // Filter time base: the filter step is one millisecond.
    localparam int                 STCS_CLK_HZ      = 25000000;
    localparam int                 STCS_FILTER_TICK_MS = 1;
    localparam int                 STCS_TICK_CYCLES = STCS_CLK_HZ / 1000 * STCS_FILTER_TICK_MS;
    localparam int                 STCS_FRAC_BITS   = 16;
endpackage
`default_nettype wire

// *** stcs_properties.sv ***
/* Checker of the torque command unit ports: bus handshakes, flags, command.
   Assumes it is bound to stcs_top with the selects coming from host pins. */
`timescale 1ns/1ps
`default_nettype none
module stcs_properties
(
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               torque_source_select0,
    input wire logic               torque_source_select1,
    input wire logic signed [15:0] torque_cmd,
    input wire logic               torque_cmd_valid,
    input wire logic               torque_limit_valid
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Raw pin pattern; the design needs a few edges to see it.
    wire logic [1:0] sel_pins = {torque_source_select1, torque_source_select0};

    property p_wr_resp;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
    property p_wr_busy;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write taken while busy");
    property p_b_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_once: assert property (p_b_once) else $error("write answer repeated");
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
    property p_r_once;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
    endproperty
    a_r_once: assert property (p_r_once) else $error("read answer repeated");
    property p_flags;
        $past(aresetn, 2) |-> $onehot({torque_cmd_valid, torque_limit_valid});
    endproperty
    a_flags: assert property (p_flags) else $error("command role not unique");
    property p_range;
        (sel_pins != 2'h0 && $stable(sel_pins)) [*6] |->
            torque_cmd <= 16'sh01D6 && torque_cmd >= -16'sh01D6;
    endproperty
    a_range: assert property (p_range) else $error("parameter out of range");
    property p_hold;
        (sel_pins != 2'h0 && $stable(sel_pins) && !s_axi_bvalid) [*8] |=> $stable(torque_cmd);
    endproperty
    a_hold: assert property (p_hold) else $error("command moved while held");
endmodule
bind stcs_top stcs_properties u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .torque_source_select0,
    .torque_source_select1, .torque_cmd, .torque_cmd_valid, .torque_limit_valid);
`default_nettype wire

// *** stcs_sync.sv ***
/*
 * Three-stage synchroniser for digital inputs from the pins.
 * Assumes asynchronous inputs; an output changes once stages two and three agree.
 */
`timescale 1ns/1ps
`default_nettype none
module stcs_sync
#(
    parameter int W = 3
)
(
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] level_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            // Stage one feeds only stage two, so metastability stays contained.
            always_comb
            begin
                lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
            end
            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_q[i]  <= 1'b0;
                    s2_q[i]  <= 1'b0;
                    s3_q[i]  <= 1'b0;
                    lvl_q[i] <= 1'b0;
                end
                else
                begin
                    s1_q[i]  <= pin_in[i];
                    s2_q[i]  <= s1_q[i];
                    s3_q[i]  <= s2_q[i];
                    lvl_q[i] <= lvl_d[i];
                end
            end
        end
    endgenerate

    assign level_out = lvl_q;
endmodule
`default_nettype wire

// *** stcs_top.sv ***
/*
 * Torque command unit: selects the torque command from the analog input or
 * three internal parameters, scales and filters the analog path, and decodes
 * single and dual control modes. Registers over AXI4-Lite.
 * Assumes pin-level digital inputs and an analog sample in mV on aclk.
 */
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module stcs_top
    import stcs_pkg::*;
#(
    parameter int TICK_CYCLES = STCS_TICK_CYCLES
)
(
    input  wire logic               aclk,
    input  wire logic               aresetn,
    input  wire logic [11:0]        s_axi_awaddr,
    input  wire logic               s_axi_awvalid,
    output logic                    s_axi_awready,
    input  wire logic [31:0]        s_axi_wdata,
    input  wire logic [3:0]         s_axi_wstrb,
    input  wire logic               s_axi_wvalid,
    output logic                    s_axi_wready,
    output logic [1:0]              s_axi_bresp,
    output logic                    s_axi_bvalid,
    input  wire logic               s_axi_bready,
    input  wire logic [11:0]        s_axi_araddr,
    input  wire logic               s_axi_arvalid,
    output logic                    s_axi_arready,
    output logic [31:0]             s_axi_rdata,
    output logic [1:0]              s_axi_rresp,
    output logic                    s_axi_rvalid,
    input  wire logic               s_axi_rready,
    input  wire logic               torque_source_select0,
    input  wire logic               torque_source_select1,
    input  wire logic               dual_mode_switch,
    input  wire logic signed [15:0] analog_torque_mv,
    output logic signed [15:0]      torque_cmd,
    output logic                    torque_cmd_valid,
    output logic                    torque_limit_valid
);
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Register state.
    logic        [7:0]  mode_q;
    logic        [7:0]  mode_d;
    logic        [15:0] filt_time_q;
    logic        [15:0] filt_time_d;
    logic        [15:0] full_scale_q;
    logic        [15:0] full_scale_d;
    logic signed [15:0] param_q [3];
    logic signed [15:0] param_d [3];
    // Bus state.
    logic               aw_got_q;
    logic               aw_got_d;
    logic               w_got_q;
    logic               w_got_d;
    logic        [9:0]  waddr_q;
    logic        [9:0]  waddr_d;
    logic        [31:0] wdata_q;
    logic        [31:0] wdata_d;
    logic        [3:0]  wstrb_q;
    logic        [3:0]  wstrb_d;
    logic               bvalid_q;
    logic               bvalid_d;
    logic        [1:0]  bresp_q;
    logic        [1:0]  bresp_d;
    logic               rvalid_q;
    logic               rvalid_d;
    logic        [31:0] rdata_q;
    logic        [31:0] rdata_d;
    logic        [1:0]  rresp_q;
    logic        [1:0]  rresp_d;
    logic               awready_q;
    logic               wready_q;
    logic               arready_q;
    // Command path.
    logic        [2:0]  di_level;
    logic signed [15:0] filt_mv;
    logic signed [31:0] scaled;
    logic signed [15:0] cmd_q;
    logic signed [15:0] cmd_d;
    logic               tval_q;
    logic               tval_d;
    logic               lval_q;
    logic               lval_d;
    logic               torque_mode;
    logic               zero_mode;
    stcs_src_t          src;
    logic        [15:0] wmask;
    logic        [15:0] wval;
    logic signed [15:0] wsig;
    logic               wr_fire;
    logic               mode_ok;

    // Pin inputs pass four flops before anything looks at them.
    stcs_sync #(.W(3)) u_sync
    (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .pin_in    ({dual_mode_switch, torque_source_select1, torque_source_select0}),
        .level_out (di_level)
    );

    stcs_lpf #(.TICK_CYCLES(TICK_CYCLES)) u_lpf
    (
        .aclk    (aclk),
        .aresetn (aresetn),
        .x_in    (analog_torque_mv),
        .time_ms (filt_time_q),
        .y_out   (filt_mv)
    );

    // Write channel: address and data are taken in either order, then the
    // write lands and the response is raised in the same edge.
    always_comb
    begin
        aw_got_d     = aw_got_q;
        w_got_d      = w_got_q;
        waddr_d      = waddr_q;
        wdata_d      = wdata_q;
        wstrb_d      = wstrb_q;
        bvalid_d     = bvalid_q;
        bresp_d      = bresp_q;
        mode_d       = mode_q;
        filt_time_d  = filt_time_q;
        full_scale_d = full_scale_q;
        param_d      = param_q;
        wmask        = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
        wval         = 16'h0000;
        wsig         = 16'sh0000;
        mode_ok      = 1'b0;
        if (s_axi_awvalid && awready_q)
        begin
            aw_got_d = 1'b1;
            waddr_d  = s_axi_awaddr[11:2];
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        wr_fire = aw_got_q && w_got_q && !bvalid_q;
        if (bvalid_q && s_axi_bready)
        begin
            bvalid_d = 1'b0;
        end
        if (wr_fire)
        begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = RESP_OKAY;
            unique case (waddr_q)
                STCS_IDX_MODE:
                begin
                    // Zero-analog variants never pair into a dual mode.
                    unique case (wdata_q[7:0])
                        STCS_MODE_PT, STCS_MODE_PR, STCS_MODE_S, STCS_MODE_T,
                        STCS_MODE_SZ, STCS_MODE_TZ, STCS_MODE_PT_S,
                        STCS_MODE_PT_T, STCS_MODE_S_T: mode_ok = 1'b1;
                        default:                       mode_ok = 1'b0;
                    endcase
                    if (mode_ok && wstrb_q[0])
                    begin
                        mode_d = wdata_q[7:0];
                    end
                    else if (!mode_ok)
                    begin
                        bresp_d = RESP_SLVERR;
                    end
                end
                STCS_IDX_FILTER_TIME, STCS_IDX_FULL_SCALE:
                begin
                    wval = (waddr_q == STCS_IDX_FILTER_TIME) ? filt_time_q : full_scale_q;
                    wval = (wval & ~wmask) | (wdata_q[15:0] & wmask);
                    // Settings beyond 1000 saturate.
                    if (wval > STCS_SETTING_MAX)
                    begin
                        wval = STCS_SETTING_MAX;
                    end
                    if (waddr_q == STCS_IDX_FILTER_TIME)
                    begin
                        filt_time_d = wval;
                    end
                    else
                    begin
                        full_scale_d = wval;
                    end
                end
                STCS_IDX_PARAM_A, STCS_IDX_PARAM_B, STCS_IDX_PARAM_C:
                begin
                    wsig = (param_q[waddr_q[2:1] - 2'b00] & ~wmask) | (wdata_q[15:0] & wmask);
                    if (wsig > STCS_PARAM_MAX)
                    begin
                        wsig = STCS_PARAM_MAX;
                    end
                    else if (wsig < STCS_PARAM_MIN)
                    begin
                        wsig = STCS_PARAM_MIN;
                    end
                    param_d[waddr_q[2:1] - 2'b00] = wsig;
                end
                default: bresp_d = RESP_SLVERR;
            endcase
        end
    end

    // Read channel: one word returned the cycle after the address is taken.
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (rvalid_q && s_axi_rready)
        begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            unique case (s_axi_araddr[11:2])
                STCS_IDX_MODE:        rdata_d = {24'h000000, mode_q};
                STCS_IDX_FILTER_TIME: rdata_d = {16'h0000, filt_time_q};
                STCS_IDX_FULL_SCALE:  rdata_d = {16'h0000, full_scale_q};
                STCS_IDX_PARAM_A:     rdata_d = {16'h0000, param_q[0]};
                STCS_IDX_PARAM_B:     rdata_d = {16'h0000, param_q[1]};
                STCS_IDX_PARAM_C:     rdata_d = {16'h0000, param_q[2]};
                STCS_IDX_STATUS:      rdata_d = {7'h00, lval_q, tval_q, di_level, 4'h0, cmd_q};
                default:
                begin
                    rdata_d = 32'h00000000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end
    end

    // Mode decode and source select; a parameter takes effect the cycle
    // after the filtered selects change, with no trigger needed.
    always_comb
    begin
        src         = stcs_src_t'({di_level[1], di_level[0]});
        zero_mode   = (mode_q == STCS_MODE_TZ);
        unique case (mode_q)
            STCS_MODE_T, STCS_MODE_TZ:       torque_mode = 1'b1;
            STCS_MODE_PT_T, STCS_MODE_S_T:   torque_mode = di_level[2];
            default:                         torque_mode = 1'b0;
        endcase
        // Voltage in mV times scaling over 10000 gives percent.
        scaled = (32'(filt_mv) * $signed({16'h0000, full_scale_q})) / STCS_MV_DIVISOR;
        unique case (src)
            STCS_SRC_ANALOG:  cmd_d = zero_mode ? 16'sh0000 : scaled[15:0];
            STCS_SRC_PARAM_A: cmd_d = param_q[0];
            STCS_SRC_PARAM_B: cmd_d = param_q[1];
            STCS_SRC_PARAM_C: cmd_d = param_q[2];
        endcase
        tval_d = torque_mode;
        lval_d = !torque_mode;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q       <= STCS_RST_MODE;
            filt_time_q  <= STCS_RST_FILTER_TIME;
            full_scale_q <= STCS_RST_FULL_SCALE;
            param_q[0]   <= STCS_RST_PARAM;
            param_q[1]   <= STCS_RST_PARAM;
            param_q[2]   <= STCS_RST_PARAM;
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            waddr_q      <= 10'h000;
            wdata_q      <= 32'h00000000;
            wstrb_q      <= 4'h0;
            bvalid_q     <= 1'b0;
            bresp_q      <= 2'b00;
            rvalid_q     <= 1'b0;
            rdata_q      <= 32'h00000000;
            rresp_q      <= 2'b00;
            cmd_q        <= 16'sh0000;
            tval_q       <= 1'b0;
            lval_q       <= 1'b0;
        end
        else
        begin
            mode_q       <= mode_d;
            filt_time_q  <= filt_time_d;
            full_scale_q <= full_scale_d;
            param_q      <= param_d;
            aw_got_q     <= aw_got_d;
            w_got_q      <= w_got_d;
            waddr_q      <= waddr_d;
            wdata_q      <= wdata_d;
            wstrb_q      <= wstrb_d;
            bvalid_q     <= bvalid_d;
            bresp_q      <= bresp_d;
            rvalid_q     <= rvalid_d;
            rdata_q      <= rdata_d;
            rresp_q      <= rresp_d;
            cmd_q        <= cmd_d;
            tval_q       <= tval_d;
            lval_q       <= lval_d;
        end
    end

    // Ready flops: low while a channel is held or a response is pending.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
        end
        else
        begin
            awready_q <= !aw_got_d && !bvalid_d && !(s_axi_awvalid && awready_q);
            wready_q  <= !w_got_d && !bvalid_d && !(s_axi_wvalid && wready_q);
            arready_q <= !rvalid_d && !(s_axi_arvalid && arready_q);
        end
    end

    assign s_axi_awready      = awready_q;
    assign s_axi_wready       = wready_q;
    assign s_axi_arready      = arready_q;
    assign s_axi_bvalid       = bvalid_q;
    assign s_axi_bresp        = bresp_q;
    assign s_axi_rvalid       = rvalid_q;
    assign s_axi_rdata        = rdata_q;
    assign s_axi_rresp        = rresp_q;
    assign torque_cmd         = cmd_q;
    assign torque_cmd_valid   = tval_q;
    assign torque_limit_valid = lval_q;
endmodule
`default_nettype wire

// *** tb_servo_torque_command_select.sv ***
/* Bench of the torque command unit: AXI4-Lite tasks, a host model on the
   pins, and call sequences with expected values. Assumes a short tick. */
`timescale 1ns/1ps
`default_nettype none
module tb_servo_torque_command_select;
    import stcs_pkg::*;
    logic               aclk = 1'h0, aresetn = 1'h0;
    logic [11:0]        s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic               s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic               s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0]        s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]         s_axi_wstrb = 4'hF;
    logic [1:0]         s_axi_bresp, s_axi_rresp;
    logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic               torque_source_select0, torque_source_select1, dual_mode_switch;
    logic               torque_cmd_valid, torque_limit_valid;
    logic signed [15:0] analog_torque_mv, torque_cmd;
    int                 n_fail = 0, num_checks = 0, cyc = 0;
    logic [7:0]         modes [4] = '{8'h00, 8'h01, 8'h02, 8'h04};

    always #20 aclk = ~aclk;
    // A short filter tick keeps the smoothing test to a few hundred cycles.
    stcs_top #(.TICK_CYCLES(8)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .torque_source_select0, .torque_source_select1, .dual_mode_switch,
        .analog_torque_mv, .torque_cmd, .torque_cmd_valid, .torque_limit_valid);
    stcs_host_model u_host (.aclk, .torque_source_select0, .torque_source_select1,
        .dual_mode_switch, .analog_torque_mv);

    task automatic chk(input logic signed [31:0] got, input logic signed [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t: got %0d expected %0d", $time, got, exp);
        end
    endtask
    // Address and data go out together and each drops once taken.
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk(s_axi_bresp, er);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
    endtask
    // Eight edges cover the pin synchroniser and the command register.
    task automatic cmd(input logic [1:0] src, input logic sw, input logic signed [15:0] v,
                       input logic signed [31:0] e, input logic [1:0] fl);
        u_host.drive(src, sw, v);
        repeat (8) @(posedge aclk);
        chk(torque_cmd, e);
        chk({torque_cmd_valid, torque_limit_valid}, fl);
    endtask
    function automatic int pct(int v, int s);
        return v * s / STCS_MV_DIVISOR;
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Main sequence: registers, sources, roles, dual modes, filter.
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        rd(STCS_IDX_FILTER_TIME, 32'h0, 2'h0);
        rd(STCS_IDX_FULL_SCALE, 32'h64, 2'h0);
        rd(10'h3FF, 32'h0, 2'h2);
        cmd(2'h0, 1'h0, 16'sd5000, pct(5000, 100), 2'h2);
        wr(STCS_IDX_FULL_SCALE, 32'h3E8, 2'h0);
        cmd(2'h0, 1'h0, -16'sd10000, pct(-10000, 1000), 2'h2);
        wr(STCS_IDX_MODE, 32'h5, 2'h0);
        cmd(2'h0, 1'h0, 16'sd10000, 0, 2'h2);
        wr(STCS_IDX_PARAM_A, 32'h1D6, 2'h0);
        wr(STCS_IDX_PARAM_B, 32'hFFFFFE2A, 2'h0);
        wr(STCS_IDX_PARAM_C, 32'h258, 2'h0);
        cmd(2'h1, 1'h0, 16'sd10000, 470, 2'h2);
        cmd(2'h2, 1'h0, 16'sd10000, -470, 2'h2);
        cmd(2'h3, 1'h0, 16'sd10000, 470, 2'h2);
        foreach (modes[i])
        begin
            wr(STCS_IDX_MODE, {24'h0, modes[i]}, 2'h0);
            cmd(2'h0, 1'h0, 16'sd5000, pct(5000, 1000), 2'h1);
        end
        wr(STCS_IDX_MODE, 32'h7, 2'h0);
        cmd(2'h1, 1'h1, 16'sd0, 470, 2'h2);
        cmd(2'h1, 1'h0, 16'sd0, 470, 2'h1);
        wr(STCS_IDX_MODE, 32'hA, 2'h0);
        cmd(2'h2, 1'h1, 16'sd0, -470, 2'h2);
        cmd(2'h2, 1'h0, 16'sd0, -470, 2'h1);
        wr(STCS_IDX_MODE, 32'h6, 2'h0);
        cmd(2'h3, 1'h1, 16'sd0, 470, 2'h1);
        wr(STCS_IDX_MODE, 32'h8, 2'h2);
        wr(STCS_IDX_MODE, 32'hB, 2'h2);
        rd(STCS_IDX_MODE, 32'h6, 2'h0);
        wr(STCS_IDX_MODE, 32'h3, 2'h0);
        cmd(2'h0, 1'h0, 16'sd0, 0, 2'h2);
        wr(STCS_IDX_FILTER_TIME, 32'h4, 2'h0);
        u_host.drive(2'h0, 1'h0, 16'sd10000);
        repeat (8) @(posedge aclk);
        chk(torque_cmd < 1000, 1);
        repeat (400) @(posedge aclk);
        chk(torque_cmd > 998, 1);
        end_of_test();
    end
    // A run far longer than the sequence counts as a hang.
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            end_of_test();
        end
    end
endmodule
`default_nettype wire
